// ---- gcifc_pkg.sv ----
/*
 Shared constants for the frame controller: register offsets, field
 positions, reset values, slot roles and bus helpers.
 Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
package gcifc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	// Half-bit counter: 128 slots, 8 bits, 2 clock halves
	localparam int CNT_W = 11;
	localparam int SLOT_W = 7;
	localparam int GRP_W = 5;
	localparam int CI_W = 6;
	localparam int EV_W = 3;

	////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MON_TX = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_MON_RX = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_CI_TX = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CI_RX = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_EVENT = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_MASK = 8'h1C;

	////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CFG_ENABLE = 0;
	localparam int CFG_END = 1;
	localparam int CFG_DLL = 2;
	localparam int CFG_SIX = 3;
	localparam int CFG_SWAP = 4;
	localparam int CFG_GRP_LO = 8;
	localparam int ST_TX_READY = 0;
	localparam int ST_RX_READY = 1;
	localparam int ST_TX_BUSY = 2;
	localparam int EV_MON_TX = 0;
	localparam int EV_MON_RX = 1;
	localparam int EV_CI = 2;

	////////////////////////////////////////////////////////////////////
	// Reset values and masks
	localparam logic [DATA_W-1:0] CFG_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] CFG_MASK = 32'h00001F1F;
	localparam logic [CI_W-1:0] CMD_RESET = 6'h00;
	localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
	localparam logic [7:0] MON_IDLE = 8'hFF;
	localparam logic [CNT_W-1:0] HALF_STEP = 11'h001;

	// Slot roles inside the four-slot group
	localparam logic [1:0] SUB_MON = 2'h2;
	localparam logic [1:0] SUB_CTRL = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////
	// Byte-lane merge of a write into an old word
	function automatic logic [DATA_W-1:0] merge_word(input logic [DATA_W-1:0] old_w,
		input logic [DATA_W-1:0] new_w, input logic [STRB_W-1:0] strb);
		logic [DATA_W-1:0] res;
		res = old_w;
		for (int i = 0; i < STRB_W; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Word index of a byte address
	function automatic logic [ADDR_W-3:0] word_index(input logic [ADDR_W-1:0] addr);
		return addr[ADDR_W-1:2];
	endfunction

endpackage

// ---- gcifc_pin_sync.sv ----
/*
 Two-flop synchronisers for the four link pins and a falling-edge
 detector for the double-rate bit clock.
 Assumes the pins are asynchronous to aclk and the bit clock is slow
 enough (well below aclk/4) for edges to be seen.
*/
`timescale 1ns/100ps
module gcifc_pin_sync (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Raw pins
	input wire logic bit_clock_pin,
	input wire logic frame_pin,
	input wire logic line_a_pin,
	input wire logic line_b_pin,
	// Synchronised view
	output logic frame_level,
	output logic line_a_level,
	output logic line_b_level,
	output logic bit_clock_fall
);

	logic [3:0] meta;
	logic [3:0] stable;
	logic clk_prev;

	// Only the second stage is looked at downstream
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= 4'h0;
			stable <= 4'h0;
			clk_prev <= 1'b0;
			bit_clock_fall <= 1'b0;
		end else begin
			meta <= {line_b_pin, line_a_pin, frame_pin, bit_clock_pin};
			stable <= meta;
			clk_prev <= stable[0];
			bit_clock_fall <= clk_prev && !stable[0];
		end
	end

	// Data delayed to match the edge pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_level <= 1'b0;
			line_a_level <= 1'b0;
			line_b_level <= 1'b0;
		end else begin
			frame_level <= stable[1];
			line_a_level <= stable[2];
			line_b_level <= stable[3];
		end
	end

endmodule

// ---- gcifc_monitor_rx.sv ----
/*
 Monitor receive acceptance: immediate or double look, and the
 receiver's acknowledge (active low on the line).
 Assumes one frame_tick per frame, after the control byte arrived.
*/
`timescale 1ns/100ps
module gcifc_monitor_rx (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Frame data
	input wire logic frame_tick,
	input wire logic enable,
	input wire logic double_look,
	input wire logic [7:0] mon_byte,
	input wire logic mx_active,
	// Results
	output logic accept,
	output logic [7:0] accept_byte,
	output logic mr_active
);

	logic [7:0] prev_byte;
	logic prev_valid;

	wire same_twice = prev_valid && (prev_byte == mon_byte);
	wire take_now = !double_look || same_twice;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_byte <= 8'h00;
			prev_valid <= 1'b0;
			accept <= 1'b0;
			accept_byte <= 8'h00;
			mr_active <= 1'b0;
		end else begin
			accept <= 1'b0;
			if (frame_tick) begin
				if (!enable) begin
					// Raw copy every frame while the function is off
					accept <= 1'b1;
					accept_byte <= mon_byte;
					mr_active <= 1'b0;
					prev_valid <= 1'b0;
				end else if (mr_active) begin
					// Hold the acknowledge until the sender releases
					if (!mx_active) begin
						mr_active <= 1'b0;
					end
					prev_valid <= 1'b0;
				end else if (mx_active) begin
					if (take_now) begin
						accept <= 1'b1;
						accept_byte <= mon_byte;
						mr_active <= 1'b1;
						prev_valid <= 1'b0;
					end else begin
						prev_byte <= mon_byte;
						prev_valid <= 1'b1;
					end
				end else begin
					prev_valid <= 1'b0;
				end
			end
		end
	end

endmodule

// ---- gcifc_frame_controller.sv ----
/*
 Four-slot frame controller on a serial time-slot bus: monitor byte
 transfer with handshake, command/indication transfer, register file on
 AXI4-Lite, sticky events with a mask onto one interrupt line.
 Assumes the partner supplies the double-rate bit clock and the frame
 pulse; both are sampled by aclk. Slot assignment of B and D channels is
 done by another block; this one leaves those bits undriven.
*/
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
// Summary of operation
// - Frame on slots 4*group to 4*group+3
// - Only the four group slots are touched
// - Slots carry B1, B2, monitor, control byte
// - Only monitor, C/I, handshake handled here
// - Drive own MX and MR, sample partner's
// - Four wires, data line roles swappable
// - Off after reset, on by enable bit
// - Receive copies kept even while disabled
// - Transmit ready set when free, write clears
// - Ready rise sets event; mask gates interrupt
// - Idle monitor sends 0xFF
// - Accepted byte sets receive ready, readable
// - Config bit selects immediate or double look
// - Command repeats; change from next control slot
// - Indication change sets event; mask gates
// - Command/indication width four or six bits
`timescale 1ns/100ps
module gcifc_frame_controller (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [gcifc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [gcifc_pkg::DATA_W-1:0] wdata,
	input wire logic [gcifc_pkg::STRB_W-1:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [gcifc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [gcifc_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Link clock and frame pulse
	input wire logic double_rate_bit_clock,
	input wire logic frame_pulse_8k,
	// First data pin
	input wire logic serial_line_out_level,
	output logic serial_line_out_drive,
	output logic serial_line_out_oe,
	// Second data pin
	input wire logic serial_line_in_level,
	output logic serial_line_in_drive,
	output logic serial_line_in_oe,
	// Interrupt
	output logic irq
);
	import gcifc_pkg::*;

	typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_RELEASE, TX_END} gcifc_tx_state_type;

	////////////////////////////////////////////////////////////////////
	// Register storage
	logic [DATA_W-1:0] frame_config_reg;
	logic [7:0] monitor_transmit_reg;
	logic [7:0] monitor_receive_reg;
	logic [CI_W-1:0] cmd_ind_transmit_reg;
	logic [CI_W-1:0] indication_value;
	logic [EV_W-1:0] misc_event_reg;
	logic [EV_W-1:0] misc_event_mask_reg;
	logic tx_full;
	logic monitor_rx_ready;

	wire frame_function_enable = frame_config_reg[CFG_ENABLE];
	wire end_of_command_flag = frame_config_reg[CFG_END];
	wire double_look_select = frame_config_reg[CFG_DLL];
	wire six_bit_cmd_ind_select = frame_config_reg[CFG_SIX];
	wire line_swap = frame_config_reg[CFG_SWAP];
	wire [GRP_W-1:0] frame_group_select = frame_config_reg[CFG_GRP_LO +: GRP_W];
	wire monitor_tx_ready = !tx_full;

	////////////////////////////////////////////////////////////////////
	// Bus slave state
	logic [ADDR_W-1:0] aw_addr_q;
	logic [DATA_W-1:0] w_data_q;
	logic [STRB_W-1:0] w_strb_q;

	wire aw_take = awvalid && awready;
	wire w_take = wvalid && wready;
	wire wr_go = !awready && !wready && !bvalid;
	wire ar_take = arvalid && arready;
	wire [ADDR_W-3:0] wr_idx = word_index(aw_addr_q);
	wire [ADDR_W-3:0] rd_idx = word_index(araddr);

	wire wr_cfg = wr_go && (wr_idx == word_index(OFF_CONFIG));
	wire wr_mon = wr_go && (wr_idx == word_index(OFF_MON_TX)) && w_strb_q[0];
	wire wr_cmd = wr_go && (wr_idx == word_index(OFF_CI_TX));
	wire wr_evt = wr_go && (wr_idx == word_index(OFF_EVENT));
	wire wr_msk = wr_go && (wr_idx == word_index(OFF_MASK));
	wire wr_ro = (wr_idx == word_index(OFF_STATUS)) || (wr_idx == word_index(OFF_MON_RX))
		|| (wr_idx == word_index(OFF_CI_RX)) || (wr_idx == word_index(OFF_MON_TX));
	wire wr_known = wr_ro || (wr_idx == word_index(OFF_CONFIG))
		|| (wr_idx == word_index(OFF_CI_TX)) || (wr_idx == word_index(OFF_EVENT))
		|| (wr_idx == word_index(OFF_MASK));
	wire rd_mon = ar_take && (rd_idx == word_index(OFF_MON_RX));

	wire [DATA_W-1:0] cfg_merged = merge_word(frame_config_reg, w_data_q, w_strb_q);
	wire [DATA_W-1:0] cmd_merged = merge_word({26'h0000000, cmd_ind_transmit_reg},
		w_data_q, w_strb_q);
	wire [DATA_W-1:0] msk_merged = merge_word({29'h00000000, misc_event_mask_reg},
		w_data_q, w_strb_q);
	wire [DATA_W-1:0] evt_clear = merge_word(32'h00000000, w_data_q, w_strb_q);

	////////////////////////////////////////////////////////////////////
	// Link sampling and bit position
	logic frame_level;
	logic line_a_level;
	logic line_b_level;
	logic bit_clock_fall;
	logic [CNT_W-1:0] half_cnt;
	logic fp_at_fall;
	logic [7:0] rx_shift;
	logic [7:0] tx_hold;
	logic [7:0] mon_rx_byte;

	gcifc_pin_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.bit_clock_pin(double_rate_bit_clock),
		.frame_pin(frame_pulse_8k),
		.line_a_pin(serial_line_out_level),
		.line_b_pin(serial_line_in_level),
		.frame_level(frame_level),
		.line_a_level(line_a_level),
		.line_b_level(line_b_level),
		.bit_clock_fall(bit_clock_fall)
	);

	// Frame starts at the first fall that sees the pulse high
	wire frame_start = bit_clock_fall && frame_level && !fp_at_fall;
	wire [CNT_W-1:0] next_half = frame_start ? '0 : half_cnt + HALF_STEP;
	wire [SLOT_W-1:0] next_slot = next_half[CNT_W-1:4];
	wire [2:0] next_bit = next_half[3:1];
	wire launch = bit_clock_fall && !next_half[0];
	wire sample = bit_clock_fall && next_half[0];
	wire grp_hit = (next_slot[SLOT_W-1:2] == frame_group_select);
	wire [1:0] sub = next_slot[1:0];
	wire rx_level = line_swap ? line_a_level : line_b_level;
	wire [7:0] rx_byte_now = {rx_shift[6:0], rx_level};
	wire byte_done = sample && (next_bit == 3'h7) && grp_hit;
	wire mon_done = byte_done && (sub == SUB_MON);
	wire frame_tick = byte_done && (sub == SUB_CTRL);

	////////////////////////////////////////////////////////////////////
	// Control byte receive
	wire partner_mx_active = !rx_byte_now[0];
	wire partner_mr_active = !rx_byte_now[1];
	wire [CI_W-1:0] ind_new = six_bit_cmd_ind_select ? rx_byte_now[7:2] :
		{2'b00, rx_byte_now[5:2]};
	wire ind_change = frame_tick && (ind_new != indication_value);

	logic mon_accept;
	logic [7:0] mon_accept_byte;
	logic mr_active;

	gcifc_monitor_rx u_mon_rx (
		.aclk(aclk),
		.aresetn(aresetn),
		.frame_tick(frame_tick),
		.enable(frame_function_enable),
		.double_look(double_look_select),
		.mon_byte(mon_rx_byte),
		.mx_active(partner_mx_active),
		.accept(mon_accept),
		.accept_byte(mon_accept_byte),
		.mr_active(mr_active)
	);

	////////////////////////////////////////////////////////////////////
	// Monitor transmit sequencing
	gcifc_tx_state_type tx_state;
	gcifc_tx_state_type next_tx_state;
	logic [7:0] tx_cur;
	logic tx_cur_last;

	wire tx_step = frame_tick && frame_function_enable;
	wire tx_load = tx_step && tx_full && ((tx_state == TX_IDLE) || (tx_state == TX_RELEASE));
	wire tx_acked = tx_step && (tx_state == TX_SEND) && partner_mr_active;
	wire tx_done_last = tx_acked && tx_cur_last;

	always_comb begin
		next_tx_state = tx_state;
		if (!frame_function_enable) begin
			next_tx_state = TX_IDLE;
		end else if (tx_step) begin
			case (tx_state)
				TX_IDLE: begin
					if (tx_full) begin
						next_tx_state = TX_SEND;
					end
				end
				TX_SEND: begin
					if (partner_mr_active) begin
						next_tx_state = tx_cur_last ? TX_END : TX_RELEASE;
					end
				end
				TX_RELEASE: begin
					if (tx_full) begin
						next_tx_state = TX_SEND;
					end
				end
				TX_END: begin
					next_tx_state = TX_IDLE;
				end
				default: begin
					next_tx_state = TX_IDLE;
				end
			endcase
		end
	end

	// Byte stays on the line through the release frame
	wire mon_busy = (tx_state == TX_SEND) || (tx_state == TX_RELEASE);
	wire [7:0] mon_out = mon_busy ? tx_cur : MON_IDLE;
	wire own_mx = (tx_state != TX_SEND);
	wire own_mr = !mr_active;
	wire [7:0] ctrl_out = six_bit_cmd_ind_select ? {cmd_ind_transmit_reg, own_mr, own_mx} :
		{2'b00, cmd_ind_transmit_reg[3:0], own_mr, own_mx};
	// Byte captured at its first bit so a change lands on a slot edge
	wire [7:0] live_byte = (sub == SUB_MON) ? mon_out : ctrl_out;
	wire [7:0] cur_byte = (next_bit == 3'h0) ? live_byte : tx_hold;
	wire [2:0] bit_pos = 3'h7 - next_bit;
	wire ctrl_bit_own = (bit_pos < 3'h6) || six_bit_cmd_ind_select;
	wire slot_own = (sub == SUB_MON) || ((sub == SUB_CTRL) && ctrl_bit_own);
	wire drive_en = frame_function_enable && grp_hit && slot_own;

	////////////////////////////////////////////////////////////////////
	// Link timing and shifting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			half_cnt <= '0;
			fp_at_fall <= 1'b0;
			rx_shift <= 8'h00;
			mon_rx_byte <= 8'h00;
			tx_hold <= 8'h00;
		end else if (bit_clock_fall) begin
			half_cnt <= next_half;
			fp_at_fall <= frame_level;
			if (sample) begin
				rx_shift <= rx_byte_now;
			end
			if (mon_done) begin
				mon_rx_byte <= rx_byte_now;
			end
			if (launch && (next_bit == 3'h0)) begin
				tx_hold <= live_byte;
			end
		end
	end

	// Pin drive, one bit per two clock halves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_line_out_drive <= 1'b0;
			serial_line_out_oe <= 1'b0;
			serial_line_in_drive <= 1'b0;
			serial_line_in_oe <= 1'b0;
		end else if (launch) begin
			serial_line_out_drive <= cur_byte[bit_pos];
			serial_line_in_drive <= cur_byte[bit_pos];
			serial_line_out_oe <= drive_en && !line_swap;
			serial_line_in_oe <= drive_en && line_swap;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Monitor transmit and receive state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state <= TX_IDLE;
			tx_full <= 1'b0;
			tx_cur <= MON_IDLE;
			tx_cur_last <= 1'b0;
			monitor_transmit_reg <= MON_IDLE;
			monitor_rx_ready <= 1'b0;
			monitor_receive_reg <= 8'h00;
			indication_value <= CMD_RESET;
		end else begin
			tx_state <= next_tx_state;
			if (wr_mon) begin
				monitor_transmit_reg <= w_data_q[7:0];
			end
			// A write in the load cycle keeps the buffer full
			tx_full <= wr_mon || (tx_full && !tx_load);
			if (tx_load) begin
				tx_cur <= monitor_transmit_reg;
				tx_cur_last <= end_of_command_flag;
			end
			if (mon_accept) begin
				monitor_receive_reg <= mon_accept_byte;
			end
			monitor_rx_ready <= mon_accept || (monitor_rx_ready && !rd_mon);
			if (frame_tick) begin
				indication_value <= ind_new;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Software registers and events
	wire [EV_W-1:0] ev_set = {ind_change, mon_accept, tx_load && !wr_mon};
	wire [EV_W-1:0] ev_clr = wr_evt ? evt_clear[EV_W-1:0] : {EV_W{1'b0}};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_config_reg <= CFG_RESET;
			cmd_ind_transmit_reg <= CMD_RESET;
			misc_event_mask_reg <= MASK_RESET;
			misc_event_reg <= MASK_RESET;
			irq <= 1'b0;
		end else begin
			if (wr_cfg) begin
				frame_config_reg <= cfg_merged & CFG_MASK;
			end else if (tx_done_last) begin
				frame_config_reg[CFG_END] <= 1'b0;
			end
			if (wr_cmd) begin
				cmd_ind_transmit_reg <= cmd_merged[CI_W-1:0];
			end
			if (wr_msk) begin
				misc_event_mask_reg <= msk_merged[EV_W-1:0];
			end
			// Set wins so no event is lost to a clear
			misc_event_reg <= (misc_event_reg & ~ev_clr) | ev_set;
			irq <= |(misc_event_reg & misc_event_mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshakes
	wire [DATA_W-1:0] status_word = {29'h00000000, mon_busy, monitor_rx_ready,
		monitor_tx_ready};
	logic [DATA_W-1:0] rd_word;
	logic rd_ok;

	always_comb begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		case (rd_idx)
			word_index(OFF_CONFIG): rd_word = frame_config_reg;
			word_index(OFF_STATUS): rd_word = status_word;
			word_index(OFF_MON_TX): rd_word = {24'h000000, monitor_transmit_reg};
			word_index(OFF_MON_RX): rd_word = {24'h000000, monitor_receive_reg};
			word_index(OFF_CI_TX): rd_word = {26'h0000000, cmd_ind_transmit_reg};
			word_index(OFF_CI_RX): rd_word = {26'h0000000, indication_value};
			word_index(OFF_EVENT): rd_word = {29'h00000000, misc_event_reg};
			word_index(OFF_MASK): rd_word = {29'h00000000, misc_event_mask_reg};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else begin
			if (aw_take) begin
				awready <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (w_take) begin
				wready <= 1'b0;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end else if (ar_take) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

endmodule

// ---- gcifc_frame_controller_assertions.sv ----
/* Port checker for the frame controller.
 Bound to the top module from tb; sees its ports only. */
`timescale 1ns/100ps
module gcifc_assertions (
	// Clock, reset and bus handshakes
	input wire logic aclk, aresetn, awvalid, awready, wvalid, wready,
	input wire logic bvalid, bready, arvalid, arready, rvalid,
	input wire logic [1:0] bresp,
	// Link enables and interrupt
	input wire logic serial_line_out_oe, serial_line_in_oe, irq
);
	wire oe_any = serial_line_out_oe | serial_line_in_oe;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_ONE_PIN: assert property (!(serial_line_out_oe && serial_line_in_oe))
		else $error("both data pins driven");
	AST_QUIET_START: assert property ($rose(aresetn) |-> !irq && !oe_any)
		else $error("active output right after reset");
	// A bit lasts far longer than eight cycles
	AST_OE_SLOT: assert property ($rose(oe_any) |=> oe_any[*8])
		else $error("pin drive shorter than a bit");
	AST_B_TIME: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	AST_B_BLOCK: assert property (bvalid |-> !awready && !wready)
		else $error("new write taken while answering");
	AST_B_ONE: assert property (bvalid && bready |=> !bvalid)
		else $error("write answer repeated");
	AST_R_TIME: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	AST_R_BLOCK: assert property (rvalid |-> !arready)
		else $error("read taken while answering");
	cover property (bvalid && bresp == 2'h2);
	cover property ($rose(oe_any));
	cover property ($rose(irq));
endmodule

// ---- gcifc_partner.sv ----
/* Far-side link device: makes bit clock and frame pulse, sends its
 frame and captures the block's frame.
 Assumes pull-ups on the data pins and a group of 0 or 1. */
`timescale 1ns/100ps
module gcifc_partner (
	// Settings from the bench
	input wire logic [4:0] grp,
	input wire logic swap,
	input wire logic [7:0] mon_out,
	input wire logic [5:0] ind_out,
	input wire logic mx_out,
	// Link
	input wire logic pin_a,
	input wire logic pin_b,
	output logic bclk,
	output logic fpulse,
	output logic p_line,
	// Captured bytes
	output logic [7:0] seen_mon,
	output logic [7:0] seen_ctl,
	output logic [7:0] act_mon,
	output int frames
);
	logic [7:0] sh;
	logic [7:0] tx;
	int n;
	int s;
	initial begin
		bclk = 1'b1;
		fpulse = 1'b0;
		p_line = 1'b1;
		frames = 0;
		seen_mon = 8'hFF;
		seen_ctl = 8'hFF;
		act_mon = 8'h00;
		sh = 8'h00;
		forever begin
			for (int k = 0; k < 137; k++) begin
				fpulse = (k == 1);
				#62.5 bclk = 1'b0;
				n = (k - 1) / 2;
				s = n / 8;
				if (k > 0 && k % 2 == 0) begin
					sh = {sh[6:0], swap ? pin_b : pin_a};
					if (n % 8 == 7 && s == 4 * grp + 2) seen_mon = sh;
					if (n % 8 == 7 && s == 4 * grp + 3) seen_ctl = sh;
				end
				if (k % 2 == 1) begin
					// Own MR answers the block's MX of last frame
					tx = (s == 4 * grp + 3) ? {ind_out, seen_ctl[0], mx_out} : 8'hA5;
					tx = (s == 4 * grp + 2) ? mon_out : tx;
					p_line = tx[7 - n % 8];
				end
				#62.5 bclk = 1'b1;
			end
			if (!seen_ctl[0]) act_mon = seen_mon;
			frames++;
			// Clock stands still, line no longer valid
			p_line = ~p_line;
			#800;
		end
	end
endmodule

// ---- tb.sv ----
/* Self-checking bench for the frame controller.
 Assumes the partner model and checker files are compiled first. */
`timescale 1ns/100ps
module tb;
	import gcifc_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = 8'h00;
	logic [ADDR_W-1:0] araddr = 8'h00;
	logic [DATA_W-1:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, bclk, fpulse, p_line;
	logic serial_line_out_drive, serial_line_out_oe, serial_line_in_drive, serial_line_in_oe;
	logic [1:0] bresp, rresp, r;
	logic [DATA_W-1:0] rdata, d;
	logic [7:0] seen_mon, seen_ctl, act_mon, x, mon_out = 8'hFF;
	logic [5:0] ind_out = 6'h00, cmd;
	logic [4:0] grp = 5'h00;
	logic swap = 1'b0;
	logic mx_out = 1'b1;
	logic any_oe = 1'b0;
	int frames;
	int seed = 79;
	int failures = 0;
	int total_checks = 0;
	// Pull-ups where nobody drives
	wire pin_a = serial_line_out_oe ? serial_line_out_drive : (swap ? p_line : 1'b1);
	wire pin_b = serial_line_in_oe ? serial_line_in_drive : (swap ? 1'b1 : p_line);
	gcifc_frame_controller dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready(1'b1), .double_rate_bit_clock(bclk),
		.frame_pulse_8k(fpulse), .serial_line_out_level(pin_a), .serial_line_out_drive,
		.serial_line_out_oe, .serial_line_in_level(pin_b), .serial_line_in_drive,
		.serial_line_in_oe, .irq);
	gcifc_partner far (.grp, .swap, .mon_out, .ind_out, .mx_out, .pin_a, .pin_b, .bclk,
		.fpulse, .p_line, .seen_mon, .seen_ctl, .act_mon, .frames);
	always #5 aclk = ~aclk;
	always @(posedge aclk) if (serial_line_out_oe || serial_line_in_oe) any_oe <= 1'b1;
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rst_val(input int i);
		return (i == 1) ? 32'h1 : ((i == 2) ? 32'hFF : 32'h0);
	endfunction
	function automatic logic [31:0] cfg(input logic [7:0] bits);
		return {19'h0, grp, bits};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask
	task automatic wf(input int n);
		int f;
		f = frames + n;
		while (frames < f) @(posedge aclk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#800000;
		failures++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			rd(8'(4 * i));
			chk(d, rst_val(i));
		end
		rd(8'h20);
		chk(r, RESP_SLVERR);
		wr(8'h24, 32'h1);
		chk(r, RESP_SLVERR);
		$display("test reset done");
		grp = 5'($random(seed) & 1);
		mon_out = 8'($random(seed));
		ind_out = 6'($random(seed)) | 6'h01;
		wr(OFF_CONFIG, cfg(8'h08));
		wf(2);
		rd(OFF_MON_RX);
		chk(d, {24'h0, mon_out});
		rd(OFF_CI_RX);
		chk(d, {26'h0, ind_out});
		rd(OFF_EVENT);
		chk(d, 32'h6);
		chk(irq, 1'b0);
		wr(OFF_EVENT, 32'h7);
		wr(OFF_MASK, 32'h4);
		ind_out = ~ind_out;
		wf(2);
		chk(irq, 1'b1);
		chk(any_oe, 1'b0);
		wr(OFF_MASK, 32'h0);
		wr(OFF_EVENT, 32'h7);
		$display("test disabled done");
		cmd = 6'($random(seed));
		wr(OFF_CI_TX, {26'h0, cmd});
		wr(OFF_CONFIG, cfg(8'h01));
		wf(2);
		chk(seen_ctl[5:0], {cmd[3:0], 2'b11});
		chk(seen_ctl[7:6], 2'b11);
		chk(seen_mon, MON_IDLE);
		wr(OFF_CONFIG, cfg(8'h09));
		wf(2);
		chk(seen_ctl[7:2], cmd);
		$display("test command done");
		x = 8'($random(seed)) & 8'h7F;
		wr(OFF_CONFIG, cfg(8'h03));
		wr(OFF_MON_TX, {24'h0, x});
		rd(OFF_STATUS);
		chk(d[ST_TX_READY], 1'b0);
		wf(3);
		chk(act_mon, x);
		rd(OFF_EVENT);
		chk(d[EV_MON_TX], 1'b1);
		wr(OFF_MASK, 32'h1);
		rd(OFF_STATUS);
		chk(d[ST_TX_READY], 1'b1);
		chk(irq, 1'b1);
		wr(OFF_MASK, 32'h0);
		wf(3);
		chk(seen_mon, MON_IDLE);
		$display("test transmit done");
		x = 8'($random(seed)) & 8'h7F;
		rd(OFF_MON_RX);
		wr(OFF_CONFIG, cfg(8'h05));
		mon_out = x;
		mx_out = 1'b0;
		wf(3);
		rd(OFF_STATUS);
		chk(d[ST_RX_READY], 1'b1);
		rd(OFF_MON_RX);
		chk(d, {24'h0, x});
		chk(seen_ctl[1], 1'b0);
		mx_out = 1'b1;
		wr(OFF_CONFIG, cfg(8'h11));
		swap = 1'b1;
		wf(2);
		chk(seen_ctl[5:2], cmd[3:0]);
		mon_out = ~x;
		mx_out = 1'b0;
		wf(1);
		rd(OFF_MON_RX);
		chk(d, {24'h0, ~x});
		$display("test receive and swap done");
		tally_and_finish();
	end
endmodule
bind gcifc_frame_controller gcifc_assertions chk_i (.aclk, .aresetn, .awvalid, .awready,
	.wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .bresp,
	.serial_line_out_oe, .serial_line_in_oe, .irq);
